/* File: panel_supply_sequencer.sv */
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: rising edge, feedback high: low side on
// R2: falling edge: low off, high side on
// R3: feedback low at rising edge: skip edge
// R4: negative reference ramps down, 128 steps, 3ms
// R5: negative feedback above 450mV 55ms: fault
// R6: gate select picks pump or drain path
// R7: gate switch after delay node; else pulldown
// R8: thermal latch kills all, power cycle only
// R9: amplifiers and reference on after lockout
// R10: charge boost delay, then boost soft-start
// R11: boost regulating: boost fault on, negative pump
// R12: negative regulating: its fault, gate delay charge
// R13: positive fault detection after positive regulates
// R14: shutdown low disables boost, pumps, gate switch
// R15: any fault 55ms continuously sets fault latch
// R16: fault latch: only reference, amplifiers; toggle clears
// R17: stress test fixes positive pump at 30V
// R18: stress test pulls stress feedback pulldown low
// R19: stress test keeps negative pump normal
// R20: positive reference ramps up, 128 steps, 3ms
// R21: timers count oscillator clock; clear without fault (the code counts pclk cycles, not osc)
// R22: thermal latch independent of ordinary fault latch
module panel_supply_sequencer #(
   parameter int step_cycles = panel_supply_pkg::step_cycles_calc,
   parameter int fault_cycles = panel_supply_pkg::fault_cycles_calc
) (
   // clock and reset (power-on)
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog comparators and oscillator
   input wire logic osc,
   input wire logic vcc_ok,
   input wire logic over_temp,
   input wire panel_supply_pkg::analog_in_s ana,
   input wire panel_supply_pkg::fault_in_s flt,
   input wire logic neg_feedback_high,
   // enables toward the analog blocks
   output logic amp_ref_en,
   output logic boost_delay_charge,
   output logic boost_en,
   output logic neg_pump_en,
   output logic gate_delay_charge,
   output logic pos_pump_en,
   output logic pos_fixed_30v,
   output logic [7:0] neg_ref_code,
   output logic [7:0] pos_ref_code,
   // switches
   output logic neg_low_side_switch,
   output logic neg_high_side_switch,
   output logic pos_path_switch,
   output logic drain_path_switch_a,
   output logic drain_path_switch_b,
   output logic gate_on_pulldown,
   output logic stress_feedback_pulldown_oe,
   output logic stress_feedback_pulldown_o,
   // status
   output logic fault_latched,
   output logic thermal_latched
);

   localparam int sw = $clog2(step_cycles + 1);
   localparam int fw = $clog2(fault_cycles + 1);

   panel_supply_pkg::seq_state_e state_q, state_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic fault_q, fault_d, therm_q, therm_d;
   logic shutdown_n_prev_q, shutdown_n_prev_d;
   logic [sw-1:0] step_q, step_d;
   logic [7:0] nref_q, nref_d, pref_q, pref_d;
   logic [6:0] nstep_q, nstep_d, pstep_q, pstep_d;
   logic nramp_done_q, nramp_done_d, pramp_done_q, pramp_done_d;
   logic [fw-1:0] ftmr_q, ftmr_d;
   logic osc_q, osc_d;
   logic low_q, low_d, high_q, high_d;
   logic gsw_q, gsw_d, pos_sw_q, pos_sw_d, drn_sw_q, drn_sw_d;
   logic pulldown_q, pulldown_d;
   logic stress_q, stress_d;
   logic [7:0] en_q, en_d;

   logic shutdown_n_n, stress, run_ok, fault_now, neg_fd, boost_fd, pos_fd;

   function automatic logic past(input panel_supply_pkg::seq_state_e s, input panel_supply_pkg::seq_state_e ref_s);
      past = (s >= ref_s);
   endfunction

   assign shutdown_n_n = ctrl_q[panel_supply_pkg::ctrl_shutdown_n_bit];
   assign stress = ctrl_q[panel_supply_pkg::ctrl_stress_bit];
   assign run_ok = shutdown_n_n && !fault_q && !therm_q; // R14 R16 R8

   // apb slave, zero wait states
   always_comb begin
      ctrl_d = ctrl_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (psel && !penable) begin
         pready_d = 1'b1;
         if (paddr == panel_supply_pkg::ctrl_off) begin
            prdata_d = ctrl_q;
         end else if (paddr == panel_supply_pkg::status_off) begin
            prdata_d = {22'h0, therm_q, fault_q, ana.pos_in_reg, ana.neg_in_reg, ana.boost_in_reg,
                        state_q, vcc_ok, osc_q};
         end else if (paddr == panel_supply_pkg::ramp_off) begin
            prdata_d = {14'h0, pramp_done_q, nramp_done_q, pref_q, nref_q};
         end else if (paddr == panel_supply_pkg::fault_cnt_off) begin
            prdata_d = 32'(ftmr_q);
         end else begin
            prdata_d = 32'h0;
            pslverr_d = 1'b1;
         end
      end
      if (psel && penable && pready_q && pwrite && !pslverr_q && paddr == panel_supply_pkg::ctrl_off) begin
         ctrl_d = {29'h0, pwdata[2:0]};
      end
   end

   // sequencer, latches and timers
   always_comb begin
      state_d = state_q;
      fault_d = fault_q;
      therm_d = therm_q;
      shutdown_n_prev_d = shutdown_n_n;
      step_d = step_q;
      nref_d = nref_q;
      pref_d = pref_q;
      nstep_d = nstep_q;
      pstep_d = pstep_q;
      nramp_done_d = nramp_done_q;
      pramp_done_d = pramp_done_q;
      ftmr_d = ftmr_q;
      if (over_temp) begin
         therm_d = 1'b1; // R8 R22
      end
      if (shutdown_n_prev_q && !shutdown_n_n) begin
         fault_d = 1'b0; // R16 R22
      end
      if (!vcc_ok) begin
         state_d = panel_supply_pkg::st_off;
      end else if (!run_ok) begin
         state_d = (state_q == panel_supply_pkg::st_off) ? panel_supply_pkg::st_ref_up : state_q;
         if (past(state_q, panel_supply_pkg::st_boost_delay)) begin
            state_d = panel_supply_pkg::st_boost_delay; // R14 R16
         end
      end else begin
         case (state_q)
            panel_supply_pkg::st_off: state_d = panel_supply_pkg::st_ref_up; // R9
            panel_supply_pkg::st_ref_up: if (ana.ref_ok) state_d = panel_supply_pkg::st_boost_delay;
            panel_supply_pkg::st_boost_delay: if (ana.boost_delay_reached) state_d = panel_supply_pkg::st_boost_ss; // R10
            panel_supply_pkg::st_boost_ss: if (ana.boost_in_reg) state_d = panel_supply_pkg::st_neg_ss; // R11
            panel_supply_pkg::st_neg_ss: if (ana.neg_in_reg && nramp_done_q) state_d = panel_supply_pkg::st_gate_delay; // R12
            panel_supply_pkg::st_gate_delay: if (ana.gate_delay_reached) state_d = panel_supply_pkg::st_pos_ss; // R12
            panel_supply_pkg::st_pos_ss: if ((ana.pos_in_reg || stress) && pramp_done_q) state_d = panel_supply_pkg::st_run; // R13
            default: state_d = state_q;
         endcase
      end
      // soft-start ramps restart on each enable
      if (!past(state_q, panel_supply_pkg::st_neg_ss) || !run_ok) begin
         nref_d = panel_supply_pkg::ref_neg_start;
         nstep_d = 7'h00;
         nramp_done_d = 1'b0;
      end
      if (!past(state_q, panel_supply_pkg::st_pos_ss) || !run_ok) begin
         pref_d = 8'h00;
         pstep_d = 7'h00;
         pramp_done_d = 1'b0;
      end
      if (past(state_q, panel_supply_pkg::st_neg_ss) && run_ok) begin
         if (step_q == sw'(step_cycles - 1)) begin
            step_d = '0;
         end else begin
            step_d = step_q + 1'b1; // R21
         end
         if (step_q == sw'(step_cycles - 1)) begin
            if (!nramp_done_q) begin
               nstep_d = nstep_q + 1'b1;
               // product kept at 16 bits so that the step size does not wrap
               nref_d = 8'(panel_supply_pkg::ref_neg_start - 8'(((16'(nstep_q) + 16'h0001) * 16'h0064) >> 7)); // R4
               nramp_done_d = (nstep_q == 7'h7f);
            end
            if (past(state_q, panel_supply_pkg::st_pos_ss) && !pramp_done_q) begin
               pstep_d = pstep_q + 1'b1;
               pref_d = 8'(((16'(pstep_q) + 16'h0001) * 16'(panel_supply_pkg::ref_pos_final)) >> 7); // R20
               pramp_done_d = (pstep_q == 7'h7f);
            end
         end
      end else begin
         step_d = '0;
      end
      if (nramp_done_q) begin
         nref_d = panel_supply_pkg::ref_neg_final;
      end
      // fault timer
      if (fault_now && run_ok) begin
         ftmr_d = ftmr_q + 1'b1; // R15 R21
         if (ftmr_q == fw'(fault_cycles - 1)) begin
            fault_d = 1'b1; // R5 R15
            ftmr_d = '0;
         end
      end else begin
         ftmr_d = '0; // R21
      end
   end

   assign boost_fd = past(state_q, panel_supply_pkg::st_neg_ss); // R11
   assign neg_fd = past(state_q, panel_supply_pkg::st_gate_delay) && nramp_done_q; // R4 R12
   assign pos_fd = state_q == panel_supply_pkg::st_run && pramp_done_q && !stress; // R13 R20 R17
   assign fault_now = (boost_fd && flt.boost_uv) || (neg_fd && flt.neg_above_fault) || (pos_fd && flt.pos_uv);

   // outputs, negative pump switching, gate switch
   always_comb begin
      osc_d = osc;
      low_d = low_q;
      high_d = high_q;
      en_d[0] = past(state_q, panel_supply_pkg::st_ref_up) && !therm_q; // R9 R8
      en_d[1] = state_q == panel_supply_pkg::st_boost_delay && run_ok; // R10
      en_d[2] = past(state_q, panel_supply_pkg::st_boost_ss) && run_ok; // R10 R14
      en_d[3] = past(state_q, panel_supply_pkg::st_neg_ss) && run_ok; // R11 R19
      en_d[4] = past(state_q, panel_supply_pkg::st_gate_delay) && run_ok; // R12
      en_d[5] = past(state_q, panel_supply_pkg::st_pos_ss) && run_ok; // R12
      en_d[6] = stress && en_d[5]; // R17
      en_d[7] = 1'b0;
      gsw_d = past(state_q, panel_supply_pkg::st_pos_ss) && run_ok; // R7 R14 R16
      pulldown_d = !gsw_d; // R7
      pos_sw_d = gsw_d && ctrl_q[panel_supply_pkg::ctrl_gate_select_bit]; // R6
      drn_sw_d = gsw_d && !ctrl_q[panel_supply_pkg::ctrl_gate_select_bit]; // R6
      stress_d = stress && run_ok; // R18
      if (!en_d[3]) begin
         low_d = 1'b0;
         high_d = 1'b0;
      end else if (osc && !osc_q) begin
         if (neg_feedback_high) begin
            low_d = 1'b1; // R1
            high_d = 1'b0;
         end else begin
            low_d = 1'b0; // R3
            high_d = 1'b1;
         end
      end else if (!osc && osc_q) begin
         low_d = 1'b0; // R2
         high_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= panel_supply_pkg::st_off;
         ctrl_q <= panel_supply_pkg::ctrl_reset;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         fault_q <= 1'b0;
         therm_q <= 1'b0;
         shutdown_n_prev_q <= 1'b0;
         step_q <= '0;
         nref_q <= panel_supply_pkg::ref_neg_start;
         pref_q <= 8'h00;
         nstep_q <= 7'h00;
         pstep_q <= 7'h00;
         nramp_done_q <= 1'b0;
         pramp_done_q <= 1'b0;
         ftmr_q <= '0;
         osc_q <= 1'b0;
         low_q <= 1'b0;
         high_q <= 1'b0;
         gsw_q <= 1'b0;
         pulldown_q <= 1'b1;
         pos_sw_q <= 1'b0;
         drn_sw_q <= 1'b0;
         stress_q <= 1'b0;
         en_q <= 8'h00;
      end else begin
         state_q <= state_d;
         ctrl_q <= ctrl_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         fault_q <= fault_d;
         therm_q <= therm_d;
         shutdown_n_prev_q <= shutdown_n_prev_d;
         step_q <= step_d;
         nref_q <= nref_d;
         pref_q <= pref_d;
         nstep_q <= nstep_d;
         pstep_q <= pstep_d;
         nramp_done_q <= nramp_done_d;
         pramp_done_q <= pramp_done_d;
         ftmr_q <= ftmr_d;
         osc_q <= osc_d;
         low_q <= low_d;
         high_q <= high_d;
         gsw_q <= gsw_d;
         pulldown_q <= pulldown_d;
         pos_sw_q <= pos_sw_d;
         drn_sw_q <= drn_sw_d;
         stress_q <= stress_d;
         en_q <= en_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign amp_ref_en = en_q[0];
   assign boost_delay_charge = en_q[1];
   assign boost_en = en_q[2];
   assign neg_pump_en = en_q[3];
   assign gate_delay_charge = en_q[4];
   assign pos_pump_en = en_q[5];
   assign pos_fixed_30v = en_q[6];
   assign neg_ref_code = nref_q;
   assign pos_ref_code = pref_q;
   assign neg_low_side_switch = low_q;
   assign neg_high_side_switch = high_q;
   assign pos_path_switch = pos_sw_q;
   assign drain_path_switch_a = drn_sw_q;
   assign drain_path_switch_b = drn_sw_q;
   assign gate_on_pulldown = pulldown_q; // R7
   assign stress_feedback_pulldown_oe = stress_q; // R18
   assign stress_feedback_pulldown_o = 1'b0;
   assign fault_latched = fault_q;
   assign thermal_latched = therm_q;

endmodule

`default_nettype wire

/* File: panel_supply_pkg.sv */
package panel_supply_pkg;

   // register byte offsets
   localparam logic [11:0] ctrl_off = 12'h000;
   localparam logic [11:0] status_off = 12'h004;
   localparam logic [11:0] ramp_off = 12'h008;
   localparam logic [11:0] fault_cnt_off = 12'h00c;

   // control register fields
   localparam int ctrl_shutdown_n_bit = 0;
   localparam int ctrl_gate_select_bit = 1;
   localparam int ctrl_stress_bit = 2;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;

   // timing
   localparam int clk_period_ps = 5000;
   localparam int soft_start_us = 3000;
   localparam int fault_time_us = 55000;
   localparam int ramp_steps = 128;
   localparam int soft_start_cycles = soft_start_us * 1000 / (clk_period_ps / 1000) / 1000 * 1000 / 1000;
   localparam int step_cycles_calc = (soft_start_us * 1000 / 5) / ramp_steps;
   localparam int fault_cycles_calc = fault_time_us * 1000 / 5;

   // reference codes, 10 mV per lsb of an 8 bit dac
   localparam logic [7:0] ref_neg_start = 8'h7d;
   localparam logic [7:0] ref_neg_final = 8'h19;
   localparam logic [7:0] ref_pos_final = 8'h7d;

   typedef enum logic [2:0] {
      st_off,
      st_ref_up,
      st_boost_delay,
      st_boost_ss,
      st_neg_ss,
      st_gate_delay,
      st_pos_ss,
      st_run
   } seq_state_e;

   typedef struct packed {
      logic ref_ok;
      logic boost_delay_reached;
      logic boost_in_reg;
      logic neg_in_reg;
      logic gate_delay_reached;
      logic pos_in_reg;
   } analog_in_s;

   typedef struct packed {
      logic boost_uv;
      logic neg_above_fault;
      logic pos_uv;
   } fault_in_s;

endpackage

/* File: panel_supply_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module panel_supply_checker #(
   parameter int fault_cycles = panel_supply_pkg::fault_cycles_calc
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // analog inputs
   input wire logic vcc_ok,
   input wire logic over_temp,
   input wire panel_supply_pkg::fault_in_s flt,
   // enables
   input wire logic amp_ref_en,
   input wire logic boost_en,
   input wire logic neg_pump_en,
   input wire logic pos_pump_en,
   input wire logic [7:0] neg_ref_code,
   // switches
   input wire logic neg_low_side_switch,
   input wire logic neg_high_side_switch,
   input wire logic pos_path_switch,
   input wire logic drain_path_switch_a,
   input wire logic drain_path_switch_b,
   input wire logic gate_on_pulldown,
   // status
   input wire logic fault_latched,
   input wire logic thermal_latched
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [31:0] flt_run_q;
   logic [31:0] flt_run_d;
   // consecutive cycles with any fault input high
   always_comb flt_run_d = (|flt) ? flt_run_q + 32'h1 : 32'h0;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) flt_run_q <= 32'h0;
      else flt_run_q <= flt_run_d;
   thermal_set_a:
      assert property (over_temp |-> ##[1:3] thermal_latched) else $error("thermal latch late");
   thermal_hold_a:
      assert property (thermal_latched |=> thermal_latched) else $error("thermal latch dropped");
   thermal_off_a:
      assert property (thermal_latched [*3] |-> !amp_ref_en && !boost_en && !neg_pump_en && !pos_pump_en)
         else $error("output alive under thermal latch");
   amp_on_a:
      assert property ((vcc_ok && !over_temp && !thermal_latched) [*5] |-> amp_ref_en)
         else $error("amplifiers not enabled");
   fault_time_a:
      assert property ($rose(fault_latched) |-> flt_run_q >= fault_cycles - 2) else $error("fault latch early");
   fault_off_a:
      assert property (fault_latched [*3] |-> !boost_en && !neg_pump_en && !pos_pump_en && gate_on_pulldown)
         else $error("output alive under fault latch");
   pump_excl_a:
      assert property (!(neg_low_side_switch && neg_high_side_switch)) else $error("pump switches both on");
   gate_sel_a:
      assert property (pos_path_switch |-> !drain_path_switch_a && !drain_path_switch_b)
         else $error("gate paths both on");
   pulldown_a:
      assert property (gate_on_pulldown |-> !pos_path_switch && !drain_path_switch_a && !drain_path_switch_b)
         else $error("gate switch on while pulled down");
   neg_ref_a:
      assert property (neg_ref_code inside {[8'h19:8'h7d]}) else $error("negative reference out of range");
endmodule
bind panel_supply_sequencer panel_supply_checker #(.fault_cycles(fault_cycles)) chk_i (.pclk, .presetn,
   .vcc_ok, .over_temp, .flt, .amp_ref_en, .boost_en, .neg_pump_en, .pos_pump_en, .neg_ref_code,
   .neg_low_side_switch, .neg_high_side_switch, .pos_path_switch, .drain_path_switch_a, .drain_path_switch_b,
   .gate_on_pulldown, .fault_latched, .thermal_latched);
`default_nettype wire

/* File: analog_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
   // clock
   input wire logic pclk,
   // enables from the sequencer
   input wire logic amp_ref_en,
   input wire logic boost_delay_charge,
   input wire logic boost_en,
   input wire logic neg_pump_en,
   input wire logic gate_delay_charge,
   input wire logic pos_pump_en,
   // test controls
   input wire logic fb_high,
   input wire logic force_uv,
   input wire logic force_neg,
   // comparators and oscillator
   output logic osc,
   output panel_supply_pkg::analog_in_s ana,
   output panel_supply_pkg::fault_in_s flt,
   output logic neg_feedback_high
);
   logic [2:0] div = 3'h0;
   // oscillator runs free at an eighth of the clock
   assign osc = div[2];
   always @(posedge pclk) begin
      div <= div + 3'h1;
      ana <= {amp_ref_en, boost_delay_charge, boost_en, neg_pump_en, gate_delay_charge, pos_pump_en};
      flt <= {force_uv, force_neg, 1'b0};
   end
   assign neg_feedback_high = fb_high;
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, osc, vcc_ok, over_temp;
   logic fb_high, force_uv, force_neg, neg_feedback_high;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   panel_supply_pkg::analog_in_s ana;
   panel_supply_pkg::fault_in_s flt;
   logic amp_ref_en, boost_delay_charge, boost_en, neg_pump_en, gate_delay_charge, pos_pump_en, pos_fixed_30v;
   logic [7:0] neg_ref_code, pos_ref_code;
   logic neg_low_side_switch, neg_high_side_switch, pos_path_switch, drain_path_switch_a, drain_path_switch_b;
   logic gate_on_pulldown, stress_feedback_pulldown_oe, stress_feedback_pulldown_o, fault_latched, thermal_latched;
   int error_cnt = 0, cmp_count = 0, n, lo, hi;
   // open-drain pin with its external pull-up
   wire stress_pin = stress_feedback_pulldown_oe ? stress_feedback_pulldown_o : 1'b1;
   panel_supply_sequencer #(.step_cycles(2), .fault_cycles(50)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc, .vcc_ok, .over_temp, .ana, .flt,
      .neg_feedback_high, .amp_ref_en, .boost_delay_charge, .boost_en, .neg_pump_en, .gate_delay_charge,
      .pos_pump_en, .pos_fixed_30v, .neg_ref_code, .pos_ref_code, .neg_low_side_switch, .neg_high_side_switch,
      .pos_path_switch, .drain_path_switch_a, .drain_path_switch_b, .gate_on_pulldown,
      .stress_feedback_pulldown_oe, .stress_feedback_pulldown_o, .fault_latched, .thermal_latched);
   analog_front_model model (.pclk, .amp_ref_en, .boost_delay_charge, .boost_en, .neg_pump_en,
      .gate_delay_charge, .pos_pump_en, .fb_high, .force_uv, .force_neg, .osc, .ana, .flt, .neg_feedback_high);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pump_win(input logic fb);
      fb_high <= fb;
      repeat (16) @(posedge pclk);
      lo = 0;
      hi = 0;
      repeat (64) begin
         @(posedge pclk);
         lo += int'(neg_low_side_switch === 1'b1);
         hi += int'(neg_high_side_switch === 1'b1);
      end
   endtask
   task automatic summarize;
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {vcc_ok, over_temp, fb_high, force_uv, force_neg} = 5'h00;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'(gate_on_pulldown), 32'h1);
      apb(1'b0, panel_supply_pkg::ctrl_off, 32'h0);
      chk(rdata, panel_supply_pkg::ctrl_reset);
      vcc_ok <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(32'({amp_ref_en, boost_en}), 32'h2);
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h1);
      for (n = 0; n < 2000 && pos_pump_en !== 1'b1; n++) @(posedge pclk);
      chk(32'({boost_en, neg_pump_en, pos_pump_en}), 32'h7);
      repeat (400) @(posedge pclk);
      apb(1'b0, panel_supply_pkg::ramp_off, 32'h0);
      chk(32'(rdata[17:0]), 32'({2'h3, panel_supply_pkg::ref_pos_final, panel_supply_pkg::ref_neg_final}));
      apb(1'b0, panel_supply_pkg::status_off, 32'h0);
      chk(32'(rdata[4:2]), 32'(panel_supply_pkg::st_run));
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h3);
      repeat (4) @(posedge pclk);
      chk(32'({pos_path_switch, drain_path_switch_a, drain_path_switch_b, gate_on_pulldown}), 32'h8);
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h1);
      repeat (4) @(posedge pclk);
      chk(32'({pos_path_switch, drain_path_switch_a, drain_path_switch_b, gate_on_pulldown}), 32'h6);
      pump_win(1'b1);
      chk(32'({lo > 0, hi > 0}), 32'h3);
      pump_win(1'b0);
      chk(32'(lo), 32'h0);
      chk(32'(hi), 32'd64);
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h5);
      repeat (4) @(posedge pclk);
      chk(32'({pos_fixed_30v, stress_pin}), 32'h2);
      pump_win(1'b1);
      chk(32'(lo > 0), 32'h1);
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h1);
      repeat (4) @(posedge pclk);
      chk(32'(stress_pin), 32'h1);
      apb(1'b1, 12'h010, 32'hffff_ffff);
      chk(32'(err), 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(rdata, 32'h0);
      chk(32'(err), 32'h1);
      force_uv <= 1'b1;
      repeat (30) @(posedge pclk);
      force_uv <= 1'b0;
      repeat (4) @(posedge pclk);
      force_uv <= 1'b1;
      repeat (30) @(posedge pclk);
      chk(32'(fault_latched), 32'h0);
      for (n = 0; n < 200 && fault_latched !== 1'b1; n++) @(posedge pclk);
      chk(32'({fault_latched, n >= 15}), 32'h3);
      repeat (4) @(posedge pclk);
      chk(32'({boost_en, pos_pump_en, amp_ref_en, gate_on_pulldown}), 32'h3);
      force_uv <= 1'b0;
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h0);
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h1);
      for (n = 0; n < 500 && boost_en !== 1'b1; n++) @(posedge pclk);
      chk(32'({fault_latched, boost_en}), 32'h1);
      for (n = 0; n < 2000 && pos_pump_en !== 1'b1; n++) @(posedge pclk);
      force_neg <= 1'b1;
      for (n = 0; n < 200 && fault_latched !== 1'b1; n++) @(posedge pclk);
      chk(32'({fault_latched, n >= 45}), 32'h3);
      force_neg <= 1'b0;
      over_temp <= 1'b1;
      repeat (4) @(posedge pclk);
      over_temp <= 1'b0;
      chk(32'({thermal_latched, amp_ref_en}), 32'h2);
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h0);
      apb(1'b1, panel_supply_pkg::ctrl_off, 32'h1);
      repeat (8) @(posedge pclk);
      chk(32'({thermal_latched, boost_en}), 32'h2);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(32'(thermal_latched), 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
